//--- loop_pkg.sv
// How it works
// - Loop variable resets to pressure; measured pressure is regulated whatever the loop variable holds.
// - Each cycle the target is compared with pressure and the drive moves to cut the error.
// - Analog target code spans linearly to full-scale pressure, top code equals full scale.
// - Auto-tare resets off; the operator keeps it off except while zeroing.
// - A zero target forces the valve drive fully closed.
// - Algorithm select picks proportional-velocity or squared-rate damping for every update.
// - A clear request on a gain sets that gain to zero.
// - Proportional-velocity: error times P gain is added to the drive accumulator.
// - Proportional-velocity: present minus previous pressure times D gain is subtracted.
// - The drive accumulator holds between cycles, so it integrates the error.
// - Squared-rate mode damps using the square of the pressure rate of change.
// - Squared-rate mode damps the error before the proportional and integral terms.
// - Squared-rate mode: I gain scales convergence speed after a step.
package loop_pkg;
   localparam int DATA_W = 16;
   localparam int GAIN_W = 16;
   localparam int ACC_W = 24;
   localparam int FRAC_SH = 8;
   localparam logic [ACC_W-1:0] DRIVE_MAX = 24'h00ffff;
   localparam logic [ACC_W-1:0] DRIVE_MIN = 24'h000000;
   localparam logic [DATA_W-1:0] FULL_SCALE = 16'h7fff;
   localparam logic [DATA_W-1:0] ANALOG_TOP = 16'hffff;
   localparam int CLK_MHZ = 100;
   localparam int CYCLE_US = 500;
   localparam int CYCLE_CNT = CYCLE_US * CLK_MHZ;
   localparam int TARE_S = 30;
   localparam logic [GAIN_W-1:0] P_RESET = 16'h00c8;
   localparam logic [GAIN_W-1:0] I_RESET = 16'h00c8;
   localparam logic [GAIN_W-1:0] D_RESET = 16'h0014;
   typedef enum logic {proportional_velocity_algorithm, squared_rate_damping_algorithm} algo_t;
   typedef enum logic {loop_pressure, loop_other} loopvar_t;
   typedef struct packed {
      logic [GAIN_W-1:0] p;
      logic [GAIN_W-1:0] i;
      logic [GAIN_W-1:0] d;
   } gains_t;
endpackage

//--- cycle_tick.sv
`timescale 1ns/10ps
// Divider that marks the start of every process cycle.
module cycle_tick
   import loop_pkg::*;
#(
   parameter int COUNT = CYCLE_CNT
) (
   input wire logic clk,
   input wire logic nrst,
   output logic tick
);
   logic [31:0] cnt_q;
   wire cnt_end = (cnt_q == 32'(COUNT - 1));

   // Free running count; one enable pulse per process cycle.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 32'h0;
         tick <= 1'b0;
      end else begin
         cnt_q <= cnt_end ? 32'h0 : cnt_q + 32'h1;
         tick <= cnt_end;
      end
   end
endmodule

//--- pressure_loop.sv
`timescale 1ns/10ps
// Pressure control loop with two selectable update algorithms.
module pressure_loop
   import loop_pkg::*;
#(
   parameter int CYCLE_COUNT = CYCLE_CNT
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Configuration.
   input wire logic set_loop_var,
   input wire loopvar_t loop_var_in,
   input wire algo_t algo_sel,
   input wire logic tare_toggle,
   // Gain writes and clears.
   input wire logic gain_wr,
   input wire gains_t gain_in,
   input wire logic clr_p,
   input wire logic clr_i,
   input wire logic clr_d,
   // Process values.
   input wire logic [DATA_W-1:0] analog_target,
   input wire logic [DATA_W-1:0] pressure,
   // Outputs.
   output logic [DATA_W-1:0] valve_drive,
   output logic tare_active,
   output loopvar_t loop_var,
   output gains_t gains,
   output logic cycle_strobe
);
   logic tick;
   logic [DATA_W-1:0] prev_q;
   logic [ACC_W-1:0] acc_q;
   logic signed [ACC_W+GAIN_W+2:0] step_w;
   logic signed [ACC_W+GAIN_W+3:0] sum_w;

   cycle_tick #(.COUNT(CYCLE_COUNT)) u_tick (
      .clk(clk),
      .nrst(nrst),
      .tick(tick)
   );

   // Target scaled so the top analog code equals full-scale pressure.
   wire [DATA_W+DATA_W-1:0] scaled_w = analog_target * FULL_SCALE;
   wire [DATA_W-1:0] target_value = DATA_W'(scaled_w / {16'h0, ANALOG_TOP});
   wire target_zero = (target_value == '0);

   // Error and rate in signed form with one guard bit.
   wire signed [DATA_W:0] err_w = $signed({1'b0, target_value}) - $signed({1'b0, pressure});
   wire signed [DATA_W:0] rate_w = $signed({1'b0, pressure}) - $signed({1'b0, prev_q});
   // Squared rate keeps the sign of the rate so the damping opposes motion.
   wire signed [2*DATA_W+1:0] rate_sq_w = rate_w * rate_w;
   // Products are formed at full width first; a cast alone would size them to the operands.
   wire signed [2*DATA_W+GAIN_W+2:0] damp_full_w =
      (rate_sq_w >>> FRAC_SH) * $signed({1'b0, gains.d});
   wire signed [DATA_W+1:0] damp_w = (DATA_W+2)'(damp_full_w >>> (2*FRAC_SH));
   wire signed [DATA_W+1:0] sq_term =
      rate_w[DATA_W] ? -damp_w : damp_w;
   // Damping enters the error before the P and I products.
   wire signed [DATA_W+1:0] derr_w = $signed({err_w[DATA_W], err_w}) - sq_term;

   // Gain products, wide enough that no product can overflow.
   wire signed [ACC_W+GAIN_W+2:0] pv_p_w = err_w * $signed({1'b0, gains.p});
   wire signed [ACC_W+GAIN_W+2:0] pv_d_w = rate_w * $signed({1'b0, gains.d});
   wire signed [ACC_W+GAIN_W+2:0] sr_p_w = derr_w * $signed({1'b0, gains.p});
   wire signed [ACC_W+GAIN_W+2:0] sr_i_w = derr_w * $signed({1'b0, gains.i});

   // Per-cycle step for each algorithm.
   always_comb begin
      if (algo_sel == proportional_velocity_algorithm) begin
         step_w = (pv_p_w >>> FRAC_SH)
            - (pv_d_w >>> FRAC_SH);
      end else begin
         // P acts on damped error; I scales convergence of the residual error.
         step_w = (sr_p_w >>> (2*FRAC_SH))
            + (sr_i_w >>> FRAC_SH);
      end
      sum_w = $signed({20'h0, acc_q}) + step_w;
   end

   // Clamp instead of wrapping so a large step cannot flip the valve.
   wire sat_hi = (sum_w > $signed({20'h0, DRIVE_MAX}));
   wire sat_lo = (sum_w < $signed({20'h0, DRIVE_MIN}));
   wire [ACC_W-1:0] acc_d = target_zero ? DRIVE_MIN :
      sat_hi ? DRIVE_MAX : sat_lo ? DRIVE_MIN : ACC_W'(sum_w);

   // Accumulator only moves on a cycle tick; it holds otherwise.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         acc_q <= DRIVE_MIN;
         prev_q <= '0;
      end else if (tick) begin
         acc_q <= acc_d;
         prev_q <= pressure;
      end
   end

   // Configuration state.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         loop_var <= loop_pressure;
         tare_active <= 1'b0;
      end else begin
         if (set_loop_var) loop_var <= loop_var_in;
         if (tare_toggle) tare_active <= ~tare_active;
      end
   end

   // Gains; a clear wins over a simultaneous write.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gains <= '{p: P_RESET, i: I_RESET, d: D_RESET};
      end else begin
         if (clr_p) gains.p <= '0;
         else if (gain_wr) gains.p <= gain_in.p;
         if (clr_i) gains.i <= '0;
         else if (gain_wr) gains.i <= gain_in.i;
         if (clr_d) gains.d <= '0;
         else if (gain_wr) gains.d <= gain_in.d;
      end
   end

   // Drive and cycle strobe from flip-flops.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         valve_drive <= '0;
         cycle_strobe <= 1'b0;
      end else begin
         valve_drive <= DATA_W'(acc_q);
         cycle_strobe <= tick;
      end
   end

   sequence s_zero_tick;
      tick && target_zero;
   endsequence

   AST_ZERO_CLOSES: assert property (@(posedge clk) disable iff (!nrst)
      s_zero_tick |-> ##2 (valve_drive == '0))
      else $error("Zero target did not close the valve.");
   AST_HOLD: assert property (@(posedge clk) disable iff (!nrst)
      !tick |=> $stable(acc_q))
      else $error("Accumulator moved outside a cycle tick.");
   AST_PREV: assert property (@(posedge clk) disable iff (!nrst)
      tick |=> (prev_q == $past(pressure)))
      else $error("Previous pressure not stored.");
   AST_CLR_P: assert property (@(posedge clk) disable iff (!nrst)
      clr_p |=> (gains.p == '0))
      else $error("P gain not cleared.");
   AST_SAT: assert property (@(posedge clk) disable iff (!nrst)
      acc_q <= DRIVE_MAX)
      else $error("Accumulator above limit.");
   AST_PV_STEP: assert property (@(posedge clk) disable iff (!nrst)
      (tick && !target_zero && algo_sel == proportional_velocity_algorithm && rate_w == 0
       && err_w > 0 && gains.p > 16'h0100 && acc_q == 0) |=> (acc_q > 0))
      else $error("Positive error did not raise drive.");
   AST_TARE_TOG: assert property (@(posedge clk) disable iff (!nrst)
      !tare_toggle |=> $stable(tare_active))
      else $error("Tare changed without a request.");
   AST_LOOPVAR: assert property (@(posedge clk) disable iff (!nrst)
      !set_loop_var |=> $stable(loop_var))
      else $error("Loop variable changed without a request.");
endmodule

//--- valve_sensor_model.sv
`timescale 1ns/10ps
// Valve and relative gauge sensor; a gauge never reads absolute pressure.
module valve_sensor_model
   import loop_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Loop side.
   input wire logic [DATA_W-1:0] valve_drive,
   input wire logic cycle_strobe,
   // Bench side: hold a level promptly, or follow the valve slowly.
   input wire logic follow,
   input wire logic [DATA_W-1:0] level,
   output logic [DATA_W-1:0] pressure
);
   logic [DATA_W-1:0] plant_q;
   // The plant closes a quarter of the gap to half the drive per cycle, a slow answer.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         plant_q <= 16'h0000;
      end else if (cycle_strobe) begin
         plant_q <= DATA_W'(int'(plant_q) + (int'(valve_drive >> 1) - int'(plant_q)) / 4);
      end
   end
   assign pressure = follow ? plant_q : level;
endmodule

//--- tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb;
   import loop_pkg::*;
   int bad_count = 0;
   int comparisons = 0;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [5:0] ctl_q = 6'h00;
   loopvar_t lv_in = loop_pressure;
   algo_t algo = proportional_velocity_algorithm;
   gains_t g_in = '0;
   logic [DATA_W-1:0] target = 16'h0000;
   logic [DATA_W-1:0] level = 16'h0000;
   logic follow = 1'b0;
   logic [DATA_W-1:0] pressure, valve_drive;
   logic tare_active, cycle_strobe;
   loopvar_t loop_var;
   gains_t gains;
   always #5 clk = ~clk;
   // Eight-cycle process period keeps the run short.
   pressure_loop #(.CYCLE_COUNT(8)) DUT (.clk(clk), .nrst(nrst), .set_loop_var(ctl_q[5]),
      .loop_var_in(lv_in), .algo_sel(algo), .tare_toggle(ctl_q[4]), .gain_wr(ctl_q[3]),
      .gain_in(g_in), .clr_p(ctl_q[2]), .clr_i(ctl_q[1]), .clr_d(ctl_q[0]),
      .analog_target(target), .pressure(pressure), .valve_drive(valve_drive),
      .tare_active(tare_active), .loop_var(loop_var), .gains(gains), .cycle_strobe(cycle_strobe));
   valve_sensor_model partner (.clk(clk), .nrst(nrst), .valve_drive(valve_drive),
      .cycle_strobe(cycle_strobe), .follow(follow), .level(level), .pressure(pressure));
   // One-cycle control pulse; outputs are settled when the task returns.
   task automatic ctl(input logic [5:0] v);
      @(posedge clk);
      ctl_q <= v;
      @(posedge clk);
      ctl_q <= 6'h00;
      #1;
   endtask
   // Waits for n process cycles, each bounded so a dead strobe cannot hang the run.
   task automatic strobes(input int n);
      int w;
      repeat (n) begin
         w = 0;
         do begin @(posedge clk); #1; w++; end while (cycle_strobe !== 1'b1 && w < 20);
         `CHK("cycle_strobe", 1'b1, cycle_strobe)
         // The drive follows the strobe by one more edge.
         @(posedge clk);
         #1;
      end
   endtask
   task automatic t_reset();
      `CHK("drive", 16'h0000, valve_drive)
      `CHK("tare", 1'b0, tare_active)
      `CHK("loop_var", loop_pressure, loop_var)
      `CHK("gains", {P_RESET, I_RESET, D_RESET}, gains)
   endtask
   task automatic t_gains();
      g_in <= '{16'h0001, 16'h0002, 16'h0003};
      ctl(6'h08);
      for (int k = 0; k < 3; k++) begin
         ctl(6'h04 >> k);
         `CHK("gain clr", 16'h0000, gains[47-16*k -: 16])
      end
      g_in <= '{16'h0100, 16'h0000, 16'h0077};
      ctl(6'h09); // Write and clear together: the clear wins.
      `CHK("gains", {16'h0100, 16'h0000, 16'h0000}, gains)
   endtask
   task automatic t_pv();
      level <= 16'h7f00;
      strobes(2);
      `CHK("zero target", 16'h0000, valve_drive)
      target <= 16'hffff;
      strobes(3);
      `CHK("pv sum", 16'h02fd, valve_drive)
      g_in <= '{16'h0000, 16'h0000, 16'h0100};
      ctl(6'h08);
      level <= 16'h7f10;
      strobes(1);
      `CHK("pv rate", 16'h02ed, valve_drive)
      strobes(1);
      `CHK("pv hold", 16'h02ed, valve_drive)
      g_in <= '{16'h00c8, 16'h0000, 16'h0000};
      ctl(6'h08);
      level <= 16'h0000;
      strobes(5);
      `CHK("saturate", 16'hffff, valve_drive)
   endtask
   task automatic t_sr();
      algo <= squared_rate_damping_algorithm;
      g_in <= '{16'h00c8, 16'h00c8, 16'h0014};
      ctl(6'h08);
      target <= 16'h0000;
      follow <= 1'b1;
      strobes(2);
      `CHK("sr zero", 16'h0000, valve_drive)
      target <= 16'hffff;
      strobes(30);
      `CHK("sr drive", 1'b1, valve_drive != 16'h0000)
      `CHK("sr rise", 1'b1, pressure > 16'h0000)
   endtask
   task automatic t_tare_var();
      ctl(6'h10);
      `CHK("tare on", 1'b1, tare_active)
      target <= 16'h0000;
      strobes(40); // Held zero for the shortened settle span.
      `CHK("tare drive", 16'h0000, valve_drive)
      ctl(6'h10);
      `CHK("tare off", 1'b0, tare_active)
      lv_in <= loop_other;
      ctl(6'h20);
      `CHK("loop_var", loop_other, loop_var)
   endtask
   task automatic give_verdict();
      $display("Checks %0d, errors %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      #1;
      t_reset();
      t_gains();
      t_pv();
      t_sr();
      t_tare_var();
      give_verdict();
   end
   // Watchdog well past the roughly 700 cycles that the tests need.
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      $display("ERROR watchdog expected finish seen hang");
      give_verdict();
   end
endmodule
